/* File: rtl/core_instruction_decoder.sv */
// fetch, decode and execute logic of the 8-bit core
`timescale 1ns/1ps
module core_instruction_decoder #(
   parameter int STACK_DEPTH = core_decoder_pkg::STACK_DEPTH
) (
   input  wire  logic                                  clk,
   input  wire  logic                                  rst_n,
   output logic [core_decoder_pkg::PC_W-1:0]           prog_addr,
   input  wire  logic [core_decoder_pkg::DATA_W-1:0]   prog_data,
   input  wire  logic                                  watchdog_option,
   input  wire  logic                                  wake,
   input  wire  core_decoder_pkg::flags_s              restore_flags,
   output core_decoder_pkg::flags_s                    flags,
   output logic [core_decoder_pkg::DATA_W-1:0]         acc_value,
   output logic [core_decoder_pkg::PC_W-1:0]           pc_value,
   output logic                                        instr_done,
   output logic                                        waiting,
   output logic                                        stopped
);

   core_decoder_pkg::core_state_e      state;
   logic [2:0]                         cyc;
   logic [core_decoder_pkg::PC_W-1:0]  pc;
   logic [core_decoder_pkg::PC_W-1:0]  fetch_ptr;
   logic [7:0]                         op;
   logic [7:0]                         b1;
   logic [7:0]                         b2;
   logic [7:0]                         cur_op;
   logic [2:0]                         last_cyc;
   logic [1:0]                         cur_len;
   logic                               exec_fire;
   logic [7:0]                         acc;
   logic [7:0]                         short_reg [0:core_decoder_pkg::SHORT_REGS-1];
   logic [7:0]                         data_mem [0:255];
   logic [core_decoder_pkg::PC_W-1:0]  stack [0:STACK_DEPTH-1];
   logic [7:0]                         rd_addr;
   logic [7:0]                         rd_data;
   logic [7:0]                         wr_addr;
   logic [7:0]                         wr_data;
   logic                               wr_en;
   logic [core_decoder_pkg::PC_W-1:0]  next_pc;
   core_decoder_pkg::flags_s           next_flags;
   logic                               push;
   logic                               pop;
   logic                               enter_wait;
   logic                               enter_stop;

   // byte length by opcode
   function automatic logic [1:0] instr_len(input logic [7:0] o);
      logic [1:0] len;
      len = core_decoder_pkg::LEN_ONE;
      if (o[7] == 1'b0) begin
         len = core_decoder_pkg::LEN_ONE;
      end else if (o[7:4] == core_decoder_pkg::HI_JUMP || o[7:4] == core_decoder_pkg::HI_CALL
                   || o[7:4] == core_decoder_pkg::HI_BIT_MOD) begin
         len = core_decoder_pkg::LEN_TWO;
      end else if (o[7:4] == core_decoder_pkg::HI_BIT_TEST) begin
         len = core_decoder_pkg::LEN_THREE;
      end else if (o == core_decoder_pkg::OP_SHIFT_LEFT_ACC || o == core_decoder_pkg::OP_CLEAR_ACC) begin
         len = core_decoder_pkg::LEN_TWO;
      end else if (o[7:4] == core_decoder_pkg::HI_PAGE_X && o[3]) begin
         len = core_decoder_pkg::LEN_TWO;
      end else if (o[7:4] == core_decoder_pkg::HI_PAGE_Y && o[3]) begin
         if (o[2:0] == core_decoder_pkg::IMM_LOAD_MEM || o[2:0] == core_decoder_pkg::IMM_CLEAR) begin
            len = core_decoder_pkg::LEN_THREE;
         end else begin
            len = core_decoder_pkg::LEN_TWO;
         end
      end
      return len;
   endfunction

   // cycle count by opcode
   function automatic logic [2:0] instr_cycles(input logic [7:0] o);
      logic [2:0] n;
      n = core_decoder_pkg::CYC_STD;
      if (o[7] == 1'b0) begin
         n = core_decoder_pkg::CYC_SHORT;
      end else if (o[7:4] == core_decoder_pkg::HI_BIT_TEST) begin
         n = core_decoder_pkg::CYC_BIT_TEST;
      end else if (o[7:4] == core_decoder_pkg::HI_INHERENT && o <= core_decoder_pkg::OP_WAIT) begin
         n = core_decoder_pkg::CYC_SHORT;
      end else if (o[7:4] == core_decoder_pkg::HI_INHERENT && o > core_decoder_pkg::OP_CLEAR_ACC) begin
         n = core_decoder_pkg::CYC_SHORT;
      end
      return n;
   endfunction

   // the opcode is only latched at the end of cycle 0
   assign cur_op    = (cyc == 3'h0) ? prog_data : op;
   assign last_cyc  = instr_cycles(cur_op) - 3'h1;
   assign cur_len   = instr_len(cur_op);
   assign exec_fire = (state == core_decoder_pkg::ST_RUN) && (cyc == last_cyc);

   // sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state     <= core_decoder_pkg::ST_RUN;
         cyc       <= 3'h0;
         pc        <= core_decoder_pkg::PC_RESET;
         fetch_ptr <= core_decoder_pkg::PC_RESET;
      end else begin
         case (state)
            core_decoder_pkg::ST_RUN: begin
               if (exec_fire) begin
                  cyc       <= 3'h0;
                  pc        <= next_pc;
                  fetch_ptr <= next_pc;
                  if (enter_stop) begin
                     state <= core_decoder_pkg::ST_STOP;
                  end else if (enter_wait) begin
                     state <= core_decoder_pkg::ST_WAIT;
                  end
               end else begin
                  cyc <= cyc + 3'h1;
                  if ({1'b0, cyc} < {1'b0, cur_len} - 3'h1) begin
                     fetch_ptr <= fetch_ptr + 12'h001;
                  end
               end
            end
            default: begin
               if (wake) begin
                  state <= core_decoder_pkg::ST_RUN;
               end
            end
         endcase
      end
   end

   // instruction byte capture
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         op <= core_decoder_pkg::OP_NOP;
         b1 <= core_decoder_pkg::DATA_RESET;
         b2 <= core_decoder_pkg::DATA_RESET;
      end else if (state == core_decoder_pkg::ST_RUN) begin
         if (cyc == 3'h0) begin
            op <= prog_data;
         end
         if (cyc == 3'h1) begin
            b1 <= prog_data;
         end
         if (cyc == 3'h2) begin
            b2 <= prog_data;
         end
      end
   end

   // operand address
   always_comb begin
      rd_addr = b1;
      if (op[7:4] == core_decoder_pkg::HI_SHORT) begin
         rd_addr = {core_decoder_pkg::SHORT_BASE, op[1:0]};
      end else if ((op[7:4] == core_decoder_pkg::HI_PAGE_X || op[7:4] == core_decoder_pkg::HI_PAGE_Y)
                   && !op[3]) begin
         // indirect: bit 4 picks the pointer
         rd_addr = op[4] ? short_reg[1] : short_reg[0];
      end else if (op[7:4] == core_decoder_pkg::HI_INHERENT) begin
         rd_addr = core_decoder_pkg::ADDR_ACC;
      end
   end

   // data space read mux
   always_comb begin
      if (rd_addr == core_decoder_pkg::ADDR_ACC) begin
         rd_data = acc;
      end else if (rd_addr[7:2] == core_decoder_pkg::SHORT_BASE) begin
         rd_data = short_reg[rd_addr[1:0]];
      end else begin
         rd_data = data_mem[rd_addr];
      end
   end

   // execute
   always_comb begin
      logic [8:0] sum;
      logic [7:0] mval;
      logic [7:0] res;
      logic       cond;
      sum        = 9'h000;
      mval       = rd_data;
      res        = 8'h00;
      cond       = 1'b0;
      next_pc    = pc + {10'h000, instr_len(op)};
      next_flags = flags;
      wr_en      = 1'b0;
      wr_addr    = rd_addr;
      wr_data    = 8'h00;
      push       = 1'b0;
      pop        = 1'b0;
      enter_wait = 1'b0;
      enter_stop = 1'b0;
      if (op[7] == 1'b0) begin
         case (op[6:5])
            core_decoder_pkg::BR_NONZERO:  cond = !flags.zero;
            core_decoder_pkg::BR_ZERO:     cond = flags.zero;
            core_decoder_pkg::BR_NO_CARRY: cond = !flags.carry;
            default:                       cond = flags.carry;
         endcase
         if (cond) begin
            // forward span+1, backward span: -15..+16
            next_pc = op[4] ? pc - {8'h00, op[3:0]} : pc + {8'h00, op[3:0]} + 12'h001;
         end
      end else if (op[7:4] == core_decoder_pkg::HI_JUMP || op[7:4] == core_decoder_pkg::HI_CALL) begin
         next_pc = {op[3:0], b1};
         push    = (op[7:4] == core_decoder_pkg::HI_CALL);
      end else if (op[7:4] == core_decoder_pkg::HI_BIT_MOD) begin
         wr_en   = 1'b1;
         wr_data = rd_data;
         wr_data[op[2:0]] = !op[3];
      end else if (op[7:4] == core_decoder_pkg::HI_BIT_TEST) begin
         cond             = rd_data[op[2:0]];
         next_flags.carry = cond;
         if (cond == op[3]) begin
            next_pc = pc + {{4{b2[7]}}, b2} + {4'h0, core_decoder_pkg::BIT_TEST_BIAS};
         end
      end else if (op[7:4] == core_decoder_pkg::HI_INHERENT) begin
         wr_addr = core_decoder_pkg::ADDR_ACC;
         case (op)
            core_decoder_pkg::OP_RETURN: begin
               next_pc = stack[0];
               pop     = 1'b1;
            end
            core_decoder_pkg::OP_INT_RETURN: begin
               next_pc    = stack[0];
               pop        = 1'b1;
               next_flags = restore_flags;
            end
            core_decoder_pkg::OP_STOP: begin
               enter_stop = !watchdog_option;
               enter_wait = watchdog_option;
            end
            core_decoder_pkg::OP_WAIT: enter_wait = 1'b1;
            core_decoder_pkg::OP_COMPLEMENT_ACC: begin
               res = ~acc;
               next_flags.carry = acc[7];
            end
            core_decoder_pkg::OP_ROTATE_CARRY: begin
               res = {acc[6:0], flags.carry};
               next_flags.carry = acc[7];
            end
            core_decoder_pkg::OP_SHIFT_LEFT_ACC: begin
               res = {acc[6:0], 1'b0};
               next_flags.carry = acc[7];
            end
            core_decoder_pkg::OP_CLEAR_ACC: begin
               res = 8'h00;
               next_flags.carry = 1'b0;
            end
            default: begin
               res = acc;
            end
         endcase
         if (op >= core_decoder_pkg::OP_COMPLEMENT_ACC && op <= core_decoder_pkg::OP_CLEAR_ACC) begin
            wr_en           = 1'b1;
            wr_data         = res;
            next_flags.zero = (res == 8'h00);
         end
      end else if (op[7:4] == core_decoder_pkg::HI_PAGE_Y && op[3]
                   && op[2:0] == core_decoder_pkg::IMM_LOAD_MEM) begin
         wr_en   = 1'b1;
         wr_data = b2;
      end else if (op[7:4] == core_decoder_pkg::HI_PAGE_Y && op[3]
                   && op[2:0] == core_decoder_pkg::IMM_CLEAR) begin
         wr_en   = 1'b1;
         wr_data = 8'h00;
      end else if (op[7:4] == core_decoder_pkg::HI_PAGE_Y && op[3] && op[2:0] == 3'h7) begin
         wr_en = 1'b0;
      end else begin
         // short direct, indirect, direct and immediate accumulator forms
         if (op[7:4] == core_decoder_pkg::HI_PAGE_Y && op[3]) begin
            mval = b1;
         end
         case ((op[7:4] == core_decoder_pkg::HI_SHORT) ? {op[3], op[3], op[2]} : op[2:0])
            core_decoder_pkg::MEM_LOAD: begin
               res     = mval;
               wr_en   = 1'b1;
               wr_addr = core_decoder_pkg::ADDR_ACC;
            end
            core_decoder_pkg::MEM_STORE: begin
               res   = acc;
               wr_en = 1'b1;
            end
            core_decoder_pkg::MEM_ADD: begin
               sum = {1'b0, acc} + {1'b0, mval};
               res = sum[7:0];
               next_flags.carry = sum[8];
               wr_en   = 1'b1;
               wr_addr = core_decoder_pkg::ADDR_ACC;
            end
            core_decoder_pkg::MEM_AND: begin
               res = acc & mval;
               next_flags.carry = 1'b0;
               wr_en   = 1'b1;
               wr_addr = core_decoder_pkg::ADDR_ACC;
            end
            core_decoder_pkg::MEM_CMP, core_decoder_pkg::MEM_SUB: begin
               sum = {1'b0, acc} - {1'b0, mval};
               res = sum[7:0];
               next_flags.carry = sum[8];
               wr_en   = (op[2:0] == core_decoder_pkg::MEM_SUB);
               wr_addr = core_decoder_pkg::ADDR_ACC;
            end
            default: begin
               // short direct codes 2 and 3 fold onto increment and decrement here
               if (op[7:4] == core_decoder_pkg::HI_SHORT ? !op[2] : !op[0]) begin
                  res = mval + 8'h01;
               end else begin
                  res = mval - 8'h01;
               end
               wr_en = 1'b1;
            end
         endcase
         wr_data         = res;
         next_flags.zero = (res == 8'h00);
      end
   end

   // flags
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags <= '0;
      end else if (exec_fire) begin
         flags <= next_flags;
      end
   end

   // accumulator lives at the top of data space
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc <= core_decoder_pkg::DATA_RESET;
      end else if (exec_fire && wr_en && wr_addr == core_decoder_pkg::ADDR_ACC) begin
         acc <= wr_data;
      end
   end

   // pointer and short-direct registers
   genvar gi;
   generate
      for (gi = 0; gi < core_decoder_pkg::SHORT_REGS; gi++) begin : g_short
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               short_reg[gi] <= core_decoder_pkg::DATA_RESET;
            end else if (exec_fire && wr_en
                         && wr_addr == {core_decoder_pkg::SHORT_BASE, 2'(gi)}) begin
               short_reg[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // general data space is not cleared at reset
   always_ff @(posedge clk) begin
      if (exec_fire && wr_en) begin
         data_mem[wr_addr] <= wr_data;
      end
   end

   // shift stack: overflow drops the oldest entry, underflow repeats it
   generate
      for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               stack[gi] <= core_decoder_pkg::PC_RESET;
            end else if (exec_fire && push) begin
               stack[gi] <= (gi == 0) ? pc + 12'h002 : stack[(gi == 0) ? 0 : gi-1];
            end else if (exec_fire && pop && gi < STACK_DEPTH-1) begin
               stack[gi] <= stack[(gi < STACK_DEPTH-1) ? gi+1 : gi];
            end
         end
      end
   endgenerate

   // status outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         instr_done <= 1'b0;
      end else begin
         instr_done <= exec_fire;
      end
   end

   assign prog_addr = fetch_ptr;
   assign acc_value = acc;
   assign pc_value  = pc;
   assign waiting   = (state == core_decoder_pkg::ST_WAIT);
   assign stopped   = (state == core_decoder_pkg::ST_STOP);

endmodule

/* File: pkg/core_decoder_pkg.sv */
// constants, opcode map and carrier types for the instruction decoder core
package core_decoder_pkg;

   localparam int PC_W        = 12;
   localparam int DATA_W      = 8;
   localparam int STACK_DEPTH = 6;
   localparam int SHORT_REGS  = 4;

   // data space map
   localparam logic [7:0] ADDR_PTR_X = 8'h80;
   localparam logic [7:0] ADDR_PTR_Y = 8'h81;
   localparam logic [7:0] ADDR_ACC   = 8'hff;
   localparam logic [5:0] SHORT_BASE = 6'h20;

   // reset values
   localparam logic [PC_W-1:0]   PC_RESET   = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

   // opcode groups, high nibble
   localparam logic [3:0] HI_JUMP     = 4'h8;
   localparam logic [3:0] HI_CALL     = 4'h9;
   localparam logic [3:0] HI_BIT_MOD  = 4'ha;
   localparam logic [3:0] HI_BIT_TEST = 4'hb;
   localparam logic [3:0] HI_SHORT    = 4'hc;
   localparam logic [3:0] HI_INHERENT = 4'hd;
   localparam logic [3:0] HI_PAGE_X   = 4'he;
   localparam logic [3:0] HI_PAGE_Y   = 4'hf;

   // inherent opcodes
   localparam logic [7:0] OP_NOP            = 8'hd0;
   localparam logic [7:0] OP_RETURN         = 8'hd1;
   localparam logic [7:0] OP_INT_RETURN     = 8'hd2;
   localparam logic [7:0] OP_STOP           = 8'hd3;
   localparam logic [7:0] OP_WAIT           = 8'hd4;
   localparam logic [7:0] OP_COMPLEMENT_ACC = 8'hd5;
   localparam logic [7:0] OP_ROTATE_CARRY   = 8'hd6;
   localparam logic [7:0] OP_SHIFT_LEFT_ACC = 8'hd7;
   localparam logic [7:0] OP_CLEAR_ACC      = 8'hd8;

   // memory-operand sub-operations, opcode bits 2:0
   localparam logic [2:0] MEM_LOAD  = 3'h0;
   localparam logic [2:0] MEM_STORE = 3'h1;
   localparam logic [2:0] MEM_ADD   = 3'h2;
   localparam logic [2:0] MEM_AND   = 3'h3;
   localparam logic [2:0] MEM_CMP   = 3'h4;
   localparam logic [2:0] MEM_SUB   = 3'h5;
   localparam logic [2:0] MEM_INC   = 3'h6;
   localparam logic [2:0] MEM_DEC   = 3'h7;

   // immediate page sub-operations (0xf8..0xff)
   localparam logic [2:0] IMM_LOAD_ACC = 3'h0;
   localparam logic [2:0] IMM_LOAD_MEM = 3'h1;
   localparam logic [2:0] IMM_CLEAR    = 3'h6;

   // short relative branch kinds, opcode bits 6:5
   localparam logic [1:0] BR_NONZERO  = 2'h0;
   localparam logic [1:0] BR_ZERO     = 2'h1;
   localparam logic [1:0] BR_NO_CARRY = 2'h2;
   localparam logic [1:0] BR_CARRY    = 2'h3;

   // cycle counts and byte lengths
   localparam logic [2:0] CYC_SHORT    = 3'h2;
   localparam logic [2:0] CYC_STD      = 3'h4;
   localparam logic [2:0] CYC_BIT_TEST = 3'h5;
   localparam logic [1:0] LEN_ONE      = 2'h1;
   localparam logic [1:0] LEN_TWO      = 2'h2;
   localparam logic [1:0] LEN_THREE    = 2'h3;
   localparam logic [7:0] BIT_TEST_BIAS = 8'h02;

   typedef struct packed {
      logic zero;
      logic carry;
   } flags_s;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_WAIT,
      ST_STOP
   } core_state_e;

endpackage

/* File: verification/core_instruction_decoder_sva.sv */
// port-level assertions for the decoder core
`timescale 1ns/1ps
module core_instruction_decoder_sva (
   input wire logic                                clk,
   input wire logic                                rst_n,
   input wire logic [core_decoder_pkg::PC_W-1:0]   prog_addr,
   input wire logic [core_decoder_pkg::DATA_W-1:0] prog_data,
   input wire logic                                watchdog_option,
   input wire core_decoder_pkg::flags_s            restore_flags,
   input wire core_decoder_pkg::flags_s            flags,
   input wire logic [core_decoder_pkg::DATA_W-1:0] acc_value,
   input wire logic [core_decoder_pkg::PC_W-1:0]   pc_value,
   input wire logic                                instr_done,
   input wire logic                                waiting,
   input wire logic                                stopped
);
   logic        start;
   logic        take;
   logic [11:0] span;
   // opcode is visible on prog_data in the cycle of the previous completion
   assign start = instr_done && !waiting && !stopped && prog_addr == pc_value;
   assign span = {8'h00, prog_data[3:0]};
   always_comb begin
      case (prog_data[6:5])
         core_decoder_pkg::BR_NONZERO:  take = !flags.zero;
         core_decoder_pkg::BR_ZERO:     take = flags.zero;
         core_decoder_pkg::BR_NO_CARRY: take = !flags.carry;
         default:                       take = flags.carry;
      endcase
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   done_pulse_a: assert property (instr_done |=> !instr_done)
      else $error("completion pulse longer than one cycle");
   end_update_a: assert property (!instr_done |-> $stable(flags) && $stable(acc_value)
      && $stable(pc_value))
      else $error("state changed outside an instruction end");
   branch_taken_a: assert property (start && !prog_data[7] && take
      |-> ##2 instr_done && flags == $past(flags, 2) && pc_value == ($past(prog_data[4], 2) ?
      $past(pc_value, 2) - $past(span, 2) : $past(pc_value, 2) + $past(span, 2) + 12'h001))
      else $error("short branch target wrong");
   branch_fall_a: assert property (start && !prog_data[7] && !take |-> ##2 instr_done
      && flags == $past(flags, 2) && pc_value == $past(pc_value, 2) + 12'h001)
      else $error("false branch did not fall through");
   long_target_a: assert property (start && prog_data[7:5] == 3'h4 |-> ##4 instr_done
      && pc_value == {$past(prog_data[3:0], 4), $past(prog_data, 3)})
      else $error("jump or call target wrong");
   bit_test_len_a: assert property (start
      && prog_data[7:4] == core_decoder_pkg::HI_BIT_TEST
      |=> !instr_done [*4] ##1 instr_done && flags.zero == $past(flags.zero, 5))
      else $error("bit test branch length or zero flag wrong");
   imm_mem_flags_a: assert property (start && prog_data == 8'hf9 |-> ##4 instr_done
      && flags == $past(flags, 4))
      else $error("immediate store changed flags");
   wait_entry_a: assert property (start && prog_data == core_decoder_pkg::OP_WAIT
      |-> ##2 instr_done && waiting && !stopped)
      else $error("wait not entered");
   stop_as_wait_a: assert property (start && prog_data == core_decoder_pkg::OP_STOP
      |-> ##2 (watchdog_option ? waiting && !stopped : stopped))
      else $error("stop handling wrong");
   int_return_a: assert property (start && prog_data == core_decoder_pkg::OP_INT_RETURN
      |-> ##2 instr_done && flags == $past(restore_flags, 2))
      else $error("interrupt return flags wrong");
endmodule
bind core_instruction_decoder core_instruction_decoder_sva u_sva (.clk(clk), .rst_n(rst_n),
   .prog_addr(prog_addr), .prog_data(prog_data), .watchdog_option(watchdog_option),
   .restore_flags(restore_flags), .flags(flags), .acc_value(acc_value),
   .pc_value(pc_value), .instr_done(instr_done), .waiting(waiting), .stopped(stopped));

/* File: verification/core_instruction_decoder_tb.sv */
// self-checking bench for the decoder core
`timescale 1ns/1ps
module core_instruction_decoder_tb;
   logic                     clk;
   logic                     rst_n;
   logic [11:0]              prog_addr;
   logic [7:0]               rom [4096];
   logic                     watchdog_option;
   logic                     wake;
   core_decoder_pkg::flags_s restore_flags;
   core_decoder_pkg::flags_s flags;
   logic [7:0]               acc_value;
   logic [11:0]              pc_value;
   logic                     instr_done;
   logic                     waiting;
   logic                     stopped;
   int                       fails;
   int                       cmp_count;
   int                       ticks;
   logic [11:0]              pc_e;

   core_instruction_decoder u_core_instruction_decoder (.clk(clk), .rst_n(rst_n),
      .prog_addr(prog_addr), .prog_data(rom[prog_addr]), .watchdog_option(watchdog_option),
      .wake(wake), .restore_flags(restore_flags), .flags(flags), .acc_value(acc_value),
      .pc_value(pc_value), .instr_done(instr_done), .waiting(waiting), .stopped(stopped));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic restart();
      rst_n = 0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1;
      pc_e = 12'h000;
   endtask

   // program memory is written just ahead of the fetch, so no image file is needed
   task automatic op(input int n, input logic [23:0] code, input int cyc,
                     input logic [11:0] npc, input logic [7:0] acc, input logic [1:0] zc);
      int k;
      for (k = 0; k < n; k++)
         rom[pc_e + k] = code[8*(n-1-k) +: 8];
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (instr_done !== 1'b1 && k < 8);
      chk("cycles", 12'(cyc), 12'(k));
      chk("pc", npc, pc_value);
      chk("acc", {4'h0, acc}, {4'h0, acc_value});
      chk("flags", {10'h000, zc}, {10'h000, flags});
      pc_e = npc;
   endtask

   task automatic sleep_check(input logic w, input logic s);
      repeat (3) @(posedge clk);
      #1 chk("waiting", {11'h000, w}, {11'h000, waiting});
      chk("stopped", {11'h000, s}, {11'h000, stopped});
      wake = 1;
      @(posedge clk);
      #1 wake = 0;
      chk("resumed", 12'h000, {10'h000, waiting, stopped});
   endtask

   task automatic t_alu();
      restart();
      op(2, 24'hf8ff, 4, 12'h002, 8'hff, 2'b00);
      op(2, 24'hfa01, 4, 12'h004, 8'h00, 2'b11);
      op(2, 24'he990, 4, 12'h006, 8'h00, 2'b11);
      op(2, 24'hee90, 4, 12'h008, 8'h00, 2'b01);
      op(2, 24'hef90, 4, 12'h00a, 8'h00, 2'b11);
      op(2, 24'hfd01, 4, 12'h00c, 8'hff, 2'b01);
      op(2, 24'hfcff, 4, 12'h00e, 8'hff, 2'b10);
      op(2, 24'hfb0f, 4, 12'h010, 8'h0f, 2'b00);
      op(1, 24'hd5, 4, 12'h011, 8'hf0, 2'b00);
      op(1, 24'hd6, 4, 12'h012, 8'he0, 2'b01);
      op(2, 24'hd700, 4, 12'h014, 8'hc0, 2'b01);
      op(2, 24'hd800, 4, 12'h016, 8'h00, 2'b10);
      op(3, 24'hf99055, 4, 12'h019, 8'h00, 2'b10);
      op(2, 24'he890, 4, 12'h01b, 8'h55, 2'b00);
      op(3, 24'hfe9000, 4, 12'h01e, 8'h55, 2'b00);
      op(2, 24'he890, 4, 12'h020, 8'h00, 2'b10);
   endtask

   task automatic t_branch();
      restart();
      op(2, 24'hf800, 4, 12'h002, 8'h00, 2'b10);
      op(1, 24'h2f, 2, 12'h012, 8'h00, 2'b10);
      op(1, 24'h15, 2, 12'h013, 8'h00, 2'b10);
      op(1, 24'h72, 2, 12'h014, 8'h00, 2'b10);
      op(2, 24'h8140, 4, 12'h140, 8'h00, 2'b10);
      op(1, 24'h5f, 2, 12'h131, 8'h00, 2'b10);
      op(2, 24'ha390, 4, 12'h133, 8'h00, 2'b10);
      op(3, 24'hb39005, 5, 12'h136, 8'h00, 2'b11);
      op(3, 24'hbb907f, 5, 12'h1b7, 8'h00, 2'b11);
      op(2, 24'hab90, 4, 12'h1b9, 8'h00, 2'b11);
      op(3, 24'hb39080, 5, 12'h13b, 8'h00, 2'b10);
   endtask

   task automatic t_call();
      restart();
      op(2, 24'h9300, 4, 12'h300, 8'h00, 2'b00);
      op(2, 24'h9500, 4, 12'h500, 8'h00, 2'b00);
      op(1, 24'hd1, 2, 12'h302, 8'h00, 2'b00);
      op(1, 24'hd1, 2, 12'h002, 8'h00, 2'b00);
      op(2, 24'h9700, 4, 12'h700, 8'h00, 2'b00);
      op(1, 24'hd2, 2, 12'h004, 8'h00, 2'b11);
      op(1, 24'hd0, 2, 12'h005, 8'h00, 2'b11);
   endtask

   // short-direct and indirect forms through the registers at 80h and 81h
   task automatic t_regs();
      restart();
      op(3, 24'hf98091, 4, 12'h003, 8'h00, 2'b00);
      op(2, 24'hf807, 4, 12'h005, 8'h07, 2'b00);
      op(1, 24'hc5, 4, 12'h006, 8'h07, 2'b00);
      op(1, 24'hc9, 4, 12'h007, 8'h07, 2'b00);
      op(1, 24'hc1, 4, 12'h008, 8'h08, 2'b00);
      op(1, 24'he1, 4, 12'h009, 8'h08, 2'b00);
      op(1, 24'he2, 4, 12'h00a, 8'h10, 2'b00);
      op(1, 24'hcd, 4, 12'h00b, 8'h10, 2'b00);
      op(1, 24'hc1, 4, 12'h00c, 8'h07, 2'b00);
   endtask

   // a nop ahead of each stop lets the checker see the stop start
   task automatic t_sleep();
      restart();
      op(1, 24'hd0, 2, 12'h001, 8'h00, 2'b00);
      op(1, 24'hd4, 2, 12'h002, 8'h00, 2'b00);
      sleep_check(1'b1, 1'b0);
      op(1, 24'hd0, 2, 12'h003, 8'h00, 2'b00);
      op(1, 24'hd3, 2, 12'h004, 8'h00, 2'b00);
      sleep_check(1'b0, 1'b1);
      watchdog_option = 1;
      op(1, 24'hd0, 2, 12'h005, 8'h00, 2'b00);
      op(1, 24'hd3, 2, 12'h006, 8'h00, 2'b00);
      sleep_check(1'b1, 1'b0);
      watchdog_option = 0;
   endtask

   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end

   // a hung handshake would otherwise stall the run forever
   always @(posedge clk) begin
      ticks++;
      if (ticks == 2000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      fails = 0;
      cmp_count = 0;
      ticks = 0;
      wake = 0;
      watchdog_option = 0;
      restore_flags = 2'b11;
      t_alu();
      t_branch();
      t_call();
      t_regs();
      t_sleep();
      wrap_up();
   end
endmodule
